/* logic/lmit_decoder.sv */
/*
 * Opcode decoder and execution timing for the loop-on-zero, limit load,
 * far stack pointer load, task register load, data moves, special
 * register moves and string move.
 * Assumes opcode, ModRM and status inputs come from core logic on
 * ref_clk and are valid together with instr_valid.
 */
`timescale 1ns/10ps
module lmit_decoder
	import lmit_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic instr_valid,
	input wire logic [7:0] opcode,
	input wire logic [7:0] opcode2,
	input wire logic [7:0] modrm,
	input wire logic prot_mode,
	input wire logic cache_miss,
	input wire logic loop_taken,
	output logic busy,
	output logic done,
	output logic [4:0] clocks,
	output logic flag_update,
	output logic invalid
);
	lmit_timer_if tif ();

	logic take;
	logic reg_op;
	logic [4:0] cnt_nxt;
	logic known_nxt;
	logic flag_nxt;
	logic [4:0] clocks_r;
	logic flag_update_r;
	logic invalid_r;
	logic [2:0] sub;

	assign take = instr_valid && !tif.busy;
	assign reg_op = (modrm[7:6] == MOD_REG);
	assign sub = modrm[5:3];

	// Register, hit or miss count by operand kind
	function automatic logic [4:0] pick(input logic is_reg,
		input logic miss, input logic [4:0] r, input logic [4:0] h,
		input logic [4:0] m);
		if (is_reg) begin
			pick = r;
		end else if (miss) begin
			pick = m;
		end else begin
			pick = h;
		end
	endfunction

	// Opcode decode into a clock count
	always_comb begin
		cnt_nxt = C_ONE;
		known_nxt = 1'b1;
		flag_nxt = 1'b0;
		if (opcode == OP_TWO_BYTE) begin
			if (opcode2 == OP2_SEG_LIMIT) begin
				// Real mode has no descriptors to read
				known_nxt = prot_mode;
				flag_nxt = prot_mode;
				cnt_nxt = pick(reg_op, cache_miss, C_SLL_REG, C_SLL_HIT,
					C_SLL_MISS);
			end else if (opcode2 == OP2_SS_FAR) begin
				if (prot_mode) begin
					cnt_nxt = cache_miss ? C_SSF_PROT_MISS : C_SSF_PROT;
				end else begin
					cnt_nxt = cache_miss ? C_SSF_REAL_MISS : C_SSF_REAL;
				end
			end else if (opcode2 == OP2_GRP_TASK) begin
				known_nxt = prot_mode && (sub == SUB_TASK_LOAD);
				cnt_nxt = pick(reg_op, cache_miss, C_TRL_REG, C_TRL_HIT,
					C_TRL_MISS);
			end else if (opcode2 == OP2_CR_WR) begin
				known_nxt = (sub == CR_ZERO) || (sub == CR_TWO) ||
					(sub == CR_THREE);
				cnt_nxt = (sub == CR_ZERO) ? C_CTL_ZERO_WR : C_THREE;
			end else if (opcode2 == OP2_CR_RD) begin
				known_nxt = (sub == CR_ZERO) || (sub == CR_TWO) ||
					(sub == CR_THREE);
				cnt_nxt = (sub == CR_ZERO) ? C_ONE : C_THREE;
			end else if (opcode2 == OP2_DR_WR) begin
				cnt_nxt = C_ONE;
			end else if (opcode2 == OP2_DR_RD) begin
				cnt_nxt = C_THREE;
			end else if (opcode2 == OP2_TR_WR) begin
				// Cache test registers are slower than the TLB ones
				known_nxt = (sub >= TR_FIRST_CACHE);
				cnt_nxt = (sub <= TR_LAST_CACHE) ? C_FIVE : C_ONE;
			end else if (opcode2 == OP2_TR_RD) begin
				known_nxt = (sub >= TR_FIRST_CACHE);
				cnt_nxt = (sub <= TR_LAST_CACHE) ? C_FIVE : C_THREE;
			end else begin
				known_nxt = 1'b0;
			end
		end else if (opcode == OP_LOOP_ZERO) begin
			cnt_nxt = loop_taken ? C_LOOP_TAKEN : C_LOOP_FALL;
		end else if (opcode[7:4] == OP_MOVE_IMM_REG) begin
			cnt_nxt = C_ONE;
		end else if (opcode[7:1] == OP_ACC_LOAD) begin
			cnt_nxt = cache_miss ? C_FOUR : C_TWO;
		end else if (opcode[7:1] == OP_ACC_STORE) begin
			// Always a memory operand, so the register count never applies
			cnt_nxt = pick(1'b0, cache_miss, C_ONE, C_TWO, C_TWO);
		end else if (opcode[7:1] == OP_STR_MOVE) begin
			cnt_nxt = C_FIVE;
		end else if (opcode[7:1] == OP_MOVE_STORE ||
			opcode[7:1] == OP_MOVE_IMM_RM) begin
			cnt_nxt = pick(reg_op, cache_miss, C_ONE, C_TWO, C_TWO);
		end else if (opcode[7:1] == OP_MOVE_LOAD) begin
			cnt_nxt = pick(reg_op, cache_miss, C_ONE, C_TWO, C_FOUR);
		end else if (opcode == OP_SREG_LOAD) begin
			if (prot_mode) begin
				cnt_nxt = pick(reg_op, cache_miss, C_SRL_PROT_REG,
					C_SRL_PROT_HIT, C_SRL_PROT_MISS);
			end else begin
				cnt_nxt = pick(reg_op, cache_miss, C_TWO, C_THREE, C_FIVE);
			end
		end else if (opcode == OP_SREG_STORE) begin
			cnt_nxt = pick(reg_op, cache_miss, C_ONE, C_TWO, C_TWO);
		end else begin
			known_nxt = 1'b0;
		end
	end

	// Start the timer only for opcodes this slice executes
	assign tif.start = take && known_nxt;
	assign tif.count = cnt_nxt;

	// Count and flag reported with each accepted instruction
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			clocks_r <= '0;
			flag_update_r <= 1'b0;
		end else if (take && known_nxt) begin
			clocks_r <= cnt_nxt;
			flag_update_r <= flag_nxt;
		end
	end

	// One-clock reject pulse; nothing is executed
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			invalid_r <= 1'b0;
		end else begin
			invalid_r <= take && !known_nxt;
		end
	end

	lmit_timer u_timer (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.tif(tif)
	);

	assign busy = tif.busy;
	assign done = tif.done;
	assign clocks = clocks_r;
	assign flag_update = flag_update_r;
	assign invalid = invalid_r;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	limit_reject_a: assert property (take && opcode == OP_TWO_BYTE &&
		opcode2 == OP2_SEG_LIMIT && !prot_mode |=> invalid && !busy)
		else $error("limit load accepted in real mode");
	limit_miss_a: assert property (take && opcode == OP_TWO_BYTE &&
		opcode2 == OP2_SEG_LIMIT && prot_mode && !reg_op && cache_miss
		|=> clocks == 5'h11 && flag_update)
		else $error("limit load miss count wrong");
	ss_far_prot_a: assert property (take && opcode == OP_TWO_BYTE &&
		opcode2 == OP2_SS_FAR && prot_mode && !cache_miss
		|=> busy [*8] ##1 busy && clocks == 5'h13)
		else $error("far stack load protected timing wrong");
	imm_reg_one_a: assert property (take && opcode[7:4] == 4'hb
		|=> busy ##1 !busy && done)
		else $error("short immediate move not one clock");
	acc_load_miss_a: assert property (take && opcode[7:1] == 7'h50 &&
		cache_miss |=> busy [*4] ##1 done && !busy)
		else $error("accumulator load miss not four clocks");
	acc_store_hit_a: assert property (take && opcode[7:1] == 7'h51 &&
		!cache_miss |=> clocks == 5'h02 ##2 done)
		else $error("accumulator store hit wrong");
	sreg_load_prot_a: assert property (take && opcode == 8'h8e &&
		prot_mode && reg_op |=> clocks == 5'h0f)
		else $error("segment load protected count wrong");
	sreg_store_miss_a: assert property (take && opcode == 8'h8c &&
		!reg_op && cache_miss |=> clocks == 5'h02)
		else $error("segment store miss count wrong");
	ctl_write_a: assert property (take && opcode == OP_TWO_BYTE &&
		opcode2 == OP2_CR_WR && sub == CR_ZERO |=> clocks == 5'h0b)
		else $error("control register zero write count wrong");
	reg_operand_a: assert property (take && opcode[7:1] == 7'h45 &&
		reg_op |=> clocks == 5'h01)
		else $error("register operand count wrong");
	mem_miss_a: assert property (take && opcode[7:1] == 7'h45 &&
		!reg_op && cache_miss |=> clocks == 5'h04)
		else $error("memory miss count wrong");

	// Further timing guards: far stack, control read, memory hit, task load
	ss_far_real_a: assert property (take && opcode == OP_TWO_BYTE &&
		opcode2 == OP2_SS_FAR && !prot_mode && cache_miss
		|=> busy [*7] ##1 done && !busy)
		else $error("far stack load real miss timing wrong");
	ctl_read_a: assert property (take && opcode == OP_TWO_BYTE &&
		opcode2 == OP2_CR_RD && sub == CR_ZERO |=> busy ##1 done && !busy)
		else $error("control register zero read not one clock");
	mem_hit_a: assert property (take && opcode[7:1] == 7'h45 &&
		!reg_op && !cache_miss |=> clocks == 5'h02)
		else $error("memory hit count wrong");
	task_load_reg_a: assert property (take && opcode == OP_TWO_BYTE &&
		opcode2 == OP2_GRP_TASK && sub == SUB_TASK_LOAD && prot_mode &&
		reg_op |=> clocks == 5'h10 && !invalid)
		else $error("task register load count wrong");
endmodule

/* logic/lmit_pkg.sv */
/*
 * Constants for the load and move timing decoder: opcode bytes, ModRM
 * fields and execution clock counts.
 * Assumes an instruction arrives as opcode byte, second byte and ModRM.
 */
package lmit_pkg;
	localparam int CNT_W = 5;
	// Opcode bytes
	localparam logic [7:0] OP_TWO_BYTE = 8'h0f;
	localparam logic [7:0] OP_LOOP_ZERO = 8'he1;
	localparam logic [7:0] OP2_SEG_LIMIT = 8'h03;
	localparam logic [7:0] OP2_SS_FAR = 8'hb2;
	localparam logic [7:0] OP2_GRP_TASK = 8'h00;
	localparam logic [7:0] OP2_CR_WR = 8'h22;
	localparam logic [7:0] OP2_CR_RD = 8'h20;
	localparam logic [7:0] OP2_DR_WR = 8'h23;
	localparam logic [7:0] OP2_DR_RD = 8'h21;
	localparam logic [7:0] OP2_TR_WR = 8'h26;
	localparam logic [7:0] OP2_TR_RD = 8'h24;
	localparam logic [6:0] OP_MOVE_STORE = 7'h44;
	localparam logic [6:0] OP_MOVE_LOAD = 7'h45;
	localparam logic [6:0] OP_MOVE_IMM_RM = 7'h63;
	localparam logic [3:0] OP_MOVE_IMM_REG = 4'hb;
	localparam logic [6:0] OP_ACC_LOAD = 7'h50;
	localparam logic [6:0] OP_ACC_STORE = 7'h51;
	localparam logic [6:0] OP_STR_MOVE = 7'h52;
	localparam logic [7:0] OP_SREG_LOAD = 8'h8e;
	localparam logic [7:0] OP_SREG_STORE = 8'h8c;
	// ModRM fields
	localparam logic [1:0] MOD_REG = 2'h3;
	localparam logic [2:0] SUB_TASK_LOAD = 3'h1;
	localparam logic [2:0] CR_ZERO = 3'h0;
	localparam logic [2:0] CR_TWO = 3'h2;
	localparam logic [2:0] CR_THREE = 3'h3;
	localparam logic [2:0] TR_FIRST_CACHE = 3'h3;
	localparam logic [2:0] TR_LAST_CACHE = 3'h5;
	// Clock counts
	localparam logic [4:0] C_LOOP_TAKEN = 5'h09;
	localparam logic [4:0] C_LOOP_FALL = 5'h03;
	localparam logic [4:0] C_SLL_REG = 5'h0e;
	localparam logic [4:0] C_SLL_HIT = 5'h0f;
	localparam logic [4:0] C_SLL_MISS = 5'h11;
	localparam logic [4:0] C_SSF_REAL = 5'h06;
	localparam logic [4:0] C_SSF_REAL_MISS = 5'h07;
	localparam logic [4:0] C_SSF_PROT = 5'h13;
	localparam logic [4:0] C_SSF_PROT_MISS = 5'h14;
	localparam logic [4:0] C_TRL_REG = 5'h10;
	localparam logic [4:0] C_TRL_HIT = 5'h11;
	localparam logic [4:0] C_TRL_MISS = 5'h12;
	localparam logic [4:0] C_ONE = 5'h01;
	localparam logic [4:0] C_TWO = 5'h02;
	localparam logic [4:0] C_THREE = 5'h03;
	localparam logic [4:0] C_FOUR = 5'h04;
	localparam logic [4:0] C_FIVE = 5'h05;
	localparam logic [4:0] C_CTL_ZERO_WR = 5'h0b;
	localparam logic [4:0] C_SRL_PROT_REG = 5'h0f;
	localparam logic [4:0] C_SRL_PROT_HIT = 5'h10;
	localparam logic [4:0] C_SRL_PROT_MISS = 5'h12;
endpackage

/* logic/lmit_timer_if.sv */
/*
 * Carrier between the decoder and its execution timer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface lmit_timer_if;
	logic start;
	logic [4:0] count;
	logic busy;
	logic done;
	modport ctl (output start, output count, input busy, input done);
	modport tmr (input start, input count, output busy, output done);
endinterface

/* logic/lmit_timer.sv */
/*
 * Execution timer: holds busy for the loaded number of clocks, then
 * pulses done for one clock.
 * Assumes start is only raised while busy is low.
 */
`timescale 1ns/10ps
module lmit_timer
	import lmit_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	lmit_timer_if.tmr tif
);
	logic [CNT_W-1:0] remain_r;
	logic busy_r;
	logic done_r;

	// Countdown; zero left means this is the last busy clock
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			busy_r <= 1'b0;
			remain_r <= '0;
		end else if (tif.start) begin
			busy_r <= 1'b1;
			remain_r <= tif.count - 5'h01;
		end else if (busy_r) begin
			if (remain_r == '0) begin
				busy_r <= 1'b0;
			end else begin
				remain_r <= remain_r - 5'h01;
			end
		end
	end

	// Completion pulse right after the last busy clock
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			done_r <= 1'b0;
		end else begin
			done_r <= busy_r && !tif.start && (remain_r == '0);
		end
	end

	assign tif.busy = busy_r;
	assign tif.done = done_r;
endmodule

/* verif/lmit_mem_model.sv */
/*
 * Far-side model: system memory that supplies memory operands.
 * Assumes the bench names which operands are absent from the cache.
 */
`timescale 1ns/10ps
module lmit_mem_model (
	input wire logic absent,
	output logic cache_miss
);
	// Zero-wait fetch only; no wait states, so miss counts stay fixed
	assign cache_miss = absent;
endmodule

/* verif/tb.sv */
/*
 * Self-checking bench for the load and move timing decoder.
 * Assumes the decoder takes a request when busy is low at the edge.
 */
`timescale 1ns/10ps
module tb;
	logic ref_clk, reset_n, instr_valid, prot_mode, absent, loop_taken;
	logic [7:0] opcode, opcode2, modrm, r;
	logic busy, done, flag_update, invalid, cache_miss;
	logic [4:0] clocks;
	int bad_count = 0;
	int n_tests = 0;
	int bcnt = 0;
	logic [5:0] expq[$];
	logic [5:0] e;

	lmit_decoder DUT (.ref_clk(ref_clk), .reset_n(reset_n),
		.instr_valid(instr_valid), .opcode(opcode), .opcode2(opcode2),
		.modrm(modrm), .prot_mode(prot_mode), .cache_miss(cache_miss),
		.loop_taken(loop_taken), .busy(busy), .done(done),
		.clocks(clocks), .flag_update(flag_update), .invalid(invalid));
	lmit_mem_model mem (.absent(absent), .cache_miss(cache_miss));

	// 100 MHz core clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Valid stays up between requests; held until the take edge
	task run(input logic [7:0] op, input logic [7:0] op2,
		input logic [7:0] rm, input logic [2:0] pml, input logic [4:0] n,
		input logic f);
		opcode = op;
		opcode2 = op2;
		modrm = rm;
		{prot_mode, absent, loop_taken} = pml;
		instr_valid = 1'b1;
		// Busy is settled a step after the edge; the next edge takes
		while (busy !== 1'b0) begin
			@(posedge ref_clk);
			#1;
		end
		@(posedge ref_clk);
		expq.push_back({f, n});
		#1;
	endtask

	// Sampled mid-cycle so edge updates have landed; n of 0 means refused
	always @(negedge ref_clk) begin
		if (busy === 1'b1)
			bcnt++;
		if (done === 1'b1 || invalid === 1'b1) begin
			if (expq.size() == 0)
				check(8'hff, 8'h00);
			else begin
				e = expq.pop_front();
				if (e[4:0] == 5'h00)
					check({7'h0, invalid}, 8'h01);
				else begin
					check({3'h0, clocks}, {3'h0, e[4:0]});
					check(8'(bcnt), {3'h0, e[4:0]});
					check({7'h0, flag_update}, {7'h0, e[5]});
				end
			end
			bcnt = 0;
		end
	end

	// Hang guard: the whole list needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		bad_count++;
		print_verdict;
	end

	// Stimulus; arguments are {prot, miss, loop}, expected clocks, flag
	initial begin
		instr_valid = 1'b0;
		opcode = 8'h00;
		opcode2 = 8'h00;
		modrm = 8'h00;
		prot_mode = 1'b0;
		absent = 1'b0;
		loop_taken = 1'b0;
		reset_n = 1'b0;
		r = 8'h00;
		void'($urandom(54008));
		repeat (5) @(posedge ref_clk);
		#1 reset_n = 1'b1;
		run(8'he1, 8'h00, 8'h00, 3'h1, 5'h09, 1'b0);
		run(8'he1, 8'h00, 8'h00, 3'h4, 5'h03, 1'b0);
		run(8'h0f, 8'h03, 8'hc0, 3'h4, 5'h0e, 1'b1);
		run(8'h0f, 8'h03, 8'h00, 3'h4, 5'h0f, 1'b1);
		run(8'h0f, 8'h03, 8'h00, 3'h6, 5'h11, 1'b1);
		run(8'h0f, 8'h03, 8'hc0, 3'h0, 5'h00, 1'b0);
		run(8'h0f, 8'hb2, 8'h00, 3'h0, 5'h06, 1'b0);
		run(8'h0f, 8'hb2, 8'h00, 3'h2, 5'h07, 1'b0);
		run(8'h0f, 8'hb2, 8'h00, 3'h4, 5'h13, 1'b0);
		run(8'h0f, 8'hb2, 8'h00, 3'h6, 5'h14, 1'b0);
		for (int i = 0; i < 4; i++) begin
			r = 8'($urandom());
			run({4'hb, r[3:0]}, r, r, {r[7], 2'h0}, 5'h01, 1'b0);
		end
		run(8'ha0, 8'h00, 8'h00, 3'h0, 5'h02, 1'b0);
		run(8'ha1, 8'h00, 8'h00, 3'h6, 5'h04, 1'b0);
		run(8'ha2, 8'h00, 8'h00, 3'h4, 5'h02, 1'b0);
		run(8'ha3, 8'h00, 8'h00, 3'h2, 5'h02, 1'b0);
		run(8'h8e, 8'h00, 8'hd8, 3'h0, 5'h02, 1'b0);
		run(8'h8e, 8'h00, 8'h18, 3'h0, 5'h03, 1'b0);
		run(8'h8e, 8'h00, 8'h18, 3'h2, 5'h05, 1'b0);
		run(8'h8e, 8'h00, 8'hd8, 3'h4, 5'h0f, 1'b0);
		run(8'h8e, 8'h00, 8'h18, 3'h4, 5'h10, 1'b0);
		run(8'h8e, 8'h00, 8'h18, 3'h6, 5'h12, 1'b0);
		run(8'h8c, 8'h00, 8'hc0, 3'h0, 5'h01, 1'b0);
		run(8'h8c, 8'h00, 8'h00, 3'h4, 5'h02, 1'b0);
		run(8'h8c, 8'h00, 8'h00, 3'h6, 5'h02, 1'b0);
		run(8'h0f, 8'h22, 8'hc0, 3'h0, 5'h0b, 1'b0);
		run(8'h0f, 8'h22, 8'hd0, 3'h4, 5'h03, 1'b0);
		run(8'h0f, 8'h22, 8'hd8, 3'h0, 5'h03, 1'b0);
		run(8'h0f, 8'h22, 8'hc8, 3'h0, 5'h00, 1'b0);
		run(8'h0f, 8'h20, 8'hc0, 3'h0, 5'h01, 1'b0);
		run(8'h0f, 8'h20, 8'hd0, 3'h4, 5'h03, 1'b0);
		run(8'h0f, 8'h20, 8'hd8, 3'h0, 5'h03, 1'b0);
		run(8'h0f, 8'h23, 8'hc0, 3'h0, 5'h01, 1'b0);
		run(8'h0f, 8'h21, 8'hc0, 3'h4, 5'h03, 1'b0);
		run(8'h0f, 8'h26, 8'hd8, 3'h0, 5'h05, 1'b0);
		run(8'h0f, 8'h00, 8'hc8, 3'h4, 5'h10, 1'b0);
		run(8'h0f, 8'h00, 8'h08, 3'h6, 5'h12, 1'b0);
		run(8'h0f, 8'h00, 8'hc8, 3'h0, 5'h00, 1'b0);
		run(8'h8b, 8'h00, 8'hc0, 3'h2, 5'h01, 1'b0);
		run(8'h8b, 8'h00, 8'h00, 3'h4, 5'h02, 1'b0);
		run(8'h8a, 8'h00, 8'h00, 3'h6, 5'h04, 1'b0);
		run(8'h88, 8'h00, 8'h00, 3'h2, 5'h02, 1'b0);
		run(8'hc7, 8'h00, 8'hc0, 3'h4, 5'h01, 1'b0);
		run(8'h0f, 8'h24, 8'hd8, 3'h4, 5'h05, 1'b0);
		run(8'h0f, 8'h24, 8'hf0, 3'h0, 5'h03, 1'b0);
		run(8'h0f, 8'h26, 8'hf8, 3'h4, 5'h01, 1'b0);
		run(8'h0f, 8'h26, 8'hc0, 3'h0, 5'h00, 1'b0);
		run(8'hff, 8'h00, 8'h00, 3'h0, 5'h00, 1'b0);
		run(8'ha4, 8'h00, 8'h00, 3'h6, 5'h05, 1'b0);
		instr_valid = 1'b0;
		repeat (30) @(posedge ref_clk);
		check(8'(expq.size()), 8'h00);
		print_verdict;
	end
endmodule
